// *** verilog/bkpt_pkg.sv ***
// Package for the breakpoint and debug exception unit.
// Assumes a single 250 MHz core clock and an APB register port.
package bkpt_pkg;
  // Register indices and APB byte offsets
  localparam logic [2:0] idx_addr0 = 3'h0;
  localparam logic [2:0] idx_alias_status = 3'h4;
  localparam logic [2:0] idx_alias_control = 3'h5;
  localparam logic [2:0] idx_status = 3'h6;
  localparam logic [2:0] idx_control = 3'h7;
  localparam logic [7:0] off_ctl4 = 8'h20;
  localparam logic [7:0] off_viol = 8'h24;
  // Control register field positions
  localparam int ctl_g0 = 1;
  localparam int ctl_le = 8;
  localparam int ctl_ge = 9;
  localparam int ctl_gd = 13;
  localparam int ctl_rw0 = 16;
  // Status register field positions
  localparam int st_bd = 13;
  localparam int st_bs = 14;
  localparam int st_bt = 15;
  // Extension enable bit in control_reg_four
  localparam int cr4_de = 3;
  // Reset values; reserved status bits except bit 12 read as ones
  localparam logic [31:0] status_reset = 32'hFFFF0FF0;
  localparam logic [31:0] status_rw_mask = 32'h0000E00F;
  localparam logic [31:0] control_reset = 32'h00000400;
  localparam logic [31:0] control_rw_mask = 32'hFFFF23FF;
  // Type and length encodings
  localparam logic [1:0] rw_exec = 2'h0;
  localparam logic [1:0] rw_write = 2'h1;
  localparam logic [1:0] rw_io = 2'h2;
  localparam logic [1:0] rw_data = 2'h3;
  localparam logic [1:0] len_two = 2'h1;
  localparam logic [1:0] len_four = 2'h3;
  // Exception vectors
  localparam logic [7:0] vec_debug = 8'h01;
  localparam logic [7:0] vec_break = 8'h03;
  localparam logic [7:0] op_int3 = 8'hCC;

  // Cycle presented by the pipeline and bus logic
  typedef struct packed {
    logic valid;
    logic is_exec;
    logic is_write;
    logic is_io;
    logic [31:0] addr;
    logic [1:0] size_m1;
  } cycle_t;

  // Exception request to the pipeline
  typedef struct packed {
    logic valid;
    logic fault;
    logic [7:0] vector;
  } exc_t;
endpackage : bkpt_pkg

// *** verilog/bkpt_compare.sv ***
// One breakpoint comparator: type and length qualified address match.
// Assumes the cycle fields are stable in the cycle they are valid.
module bkpt_compare (
  input wire logic [31:0] bp_addr,
  input wire logic [1:0] rw,
  input wire logic [1:0] len,
  input wire logic de,
  input wire bkpt_pkg::cycle_t cyc,
  output logic hit
);
  logic [31:0] mask;
  logic [31:0] lo;
  logic [31:0] hi;
  logic type_ok;

  always_comb
  begin
    unique case (len)
      bkpt_pkg::len_two: mask = 32'hFFFFFFFE;
      bkpt_pkg::len_four: mask = 32'hFFFFFFFC;
      default: mask = 32'hFFFFFFFF; // 10b undefined, treated as one byte
    endcase
  end

  assign lo = cyc.addr & mask;
  assign hi = cyc.addr + {30'h0, cyc.size_m1};
  always_comb
  begin
    unique case (rw)
      bkpt_pkg::rw_exec: type_ok = cyc.is_exec;
      bkpt_pkg::rw_write: type_ok = cyc.is_write & ~cyc.is_io & ~cyc.is_exec;
      bkpt_pkg::rw_io: type_ok = cyc.is_io & de;
      default: type_ok = ~cyc.is_io & ~cyc.is_exec;
    endcase
  end

  assign hit = cyc.valid & type_ok & ((bp_addr & mask) <= hi) &
    (((bp_addr & mask) | ~mask) >= lo);
endmodule : bkpt_compare

// *** verilog/bkpt_apb.sv ***
// APB slave front end: decodes a transfer into access strobes held through the access phase.
// Assumes an APB master on the same clock; the unit adds the wait state.
module bkpt_apb (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  output logic wr_stb,
  output logic rd_stb,
  output logic [5:0] word
);
  // Access phase strobes; the data path reads them combinationally
  assign wr_stb = psel & penable & pwrite & rst_b;
  assign rd_stb = psel & penable & ~pwrite & rst_b;
  assign word = paddr[7:2];
endmodule : bkpt_apb

// *** verilog/bkpt_unit.sv ***
// Breakpoint and debug exception unit of the core.
// Assumes the pipeline gives one retire or decode event per cycle.
// What this block does
// - four addresses compared with each cycle
// - alias slots map to status, control
// - alias slot access raises undefined opcode
// - enabled hit sets its match flag
// - disabled hits flag but never trap
// - guarded debug register access flags, faults
// - trap flag single-steps every instruction
// - task trap bit flags task switch
// - task switch clears local enables
// - global enables persist and override
// - compat exact bits stored, unused
// - guard enable cleared on debug exception
// - type field selects match kind
// - length field selects matched size
// - traps after, faults before instruction
// - data, step, task events trap
// - execution hits and guard fault
// - one-byte breakpoint opcode traps vector three
module bkpt_unit (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bkpt_pkg::cycle_t cyc,
  input wire logic retire,
  input wire logic [7:0] retire_opcode,
  input wire logic trap_flag,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  input wire logic dreg_decode,
  input wire logic [2:0] dreg_num,
  output bkpt_pkg::exc_t exc,
  output logic undef_opcode
);
  logic [31:0] bp_addr [4];
  logic [31:0] status;
  logic [31:0] control;
  logic [31:0] ctl4;
  logic [3:0] hit;
  logic [3:0] enabled;
  logic [3:0] pend_data;
  logic wr_stb;
  logic rd_stb;
  logic [5:0] word;
  logic de;
  logic alias_access;
  logic guard_fault;
  logic exec_fault;
  logic data_trap;
  logic step_trap;
  logic task_trap;
  logic int3_trap;
  logic debug_exc;
  logic [2:0] reg_idx;
  logic reg_sel;
  logic ext_sel;
  logic [3:0] match_flags;
  logic register_access_flag;
  logic single_step_flag;
  logic task_switch_flag;
  logic [31:0] next_rdata;
  logic wr_en;
  logic rd_first;
  logic wr_status;
  logic wr_control;
  logic wr_addr;
  logic wr_ext;
  logic [3:0] data_hit;

  bkpt_apb u_apb (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .word(word)
  );

  assign de = ctl4[bkpt_pkg::cr4_de];
  // Debug register words 0..7 sit at the first eight word slots
  assign reg_sel = (word[5:3] == 3'h0);
  assign reg_idx = word[2:0];
  assign ext_sel = (paddr == bkpt_pkg::off_ctl4) | (paddr == bkpt_pkg::off_viol);

  // Writes land at the one edge where pready is sampled high; the access
  // phase stands for two cycles, and a second write would overwrite
  // whatever the hardware set in between
  assign wr_en = wr_stb & pready;
  // Read data is captured once, in the first access cycle
  assign rd_first = rd_stb & ~pready;
  assign wr_status = wr_en & reg_sel & ((reg_idx == bkpt_pkg::idx_status) |
    (~de & (reg_idx == bkpt_pkg::idx_alias_status)));
  assign wr_control = wr_en & reg_sel & ((reg_idx == bkpt_pkg::idx_control) |
    (~de & (reg_idx == bkpt_pkg::idx_alias_control)));
  // Address words are the first four slots
  assign wr_addr = wr_en & reg_sel & ~reg_idx[2];
  // Extension register sits outside the debug slots
  assign wr_ext = wr_en & (paddr == bkpt_pkg::off_ctl4);

  for (genvar i = 0; i < 4; i++)
  begin : g_cmp
    bkpt_compare u_cmp (
      .bp_addr(bp_addr[i]),
      .rw(control[bkpt_pkg::ctl_rw0 + 4 * i +: 2]),
      .len(control[bkpt_pkg::ctl_rw0 + 4 * i + 2 +: 2]),
      .de(de),
      .cyc(cyc),
      .hit(hit[i])
    );
    assign enabled[i] = control[2 * i] | control[bkpt_pkg::ctl_g0 + 2 * i];
  end

  assign exec_fault = |(hit & enabled) & cyc.is_exec;
  assign guard_fault = dreg_decode & control[bkpt_pkg::ctl_gd];
  assign alias_access = dreg_decode & de & ~control[bkpt_pkg::ctl_gd] &
    ((dreg_num == bkpt_pkg::idx_alias_status) | (dreg_num == bkpt_pkg::idx_alias_control));
  // Data and I/O hits of this cycle belong to the retiring instruction too
  assign data_hit = hit & enabled & {4{~cyc.is_exec}};
  assign data_trap = retire & (|(pend_data | data_hit));
  assign step_trap = retire & trap_flag;
  assign task_trap = task_switch & task_trap_bit;
  assign int3_trap = retire & (retire_opcode == bkpt_pkg::op_int3);
  assign debug_exc = exec_fault | guard_fault | data_trap | step_trap | task_trap;

  // Data and I/O hits wait for the instruction to retire before trapping;
  // the retire consumes them, so a later instruction never inherits one
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pend_data <= 4'h0;
    else if (retire)
      pend_data <= 4'h0;
    else
      pend_data <= pend_data | data_hit;
  end

  // disabled match flag
  // A hit in the cycle of a software clear still sets its flag
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      match_flags <= bkpt_pkg::status_reset[3:0];
    else if (wr_status)
      match_flags <= pwdata[3:0] | hit;
    else
      match_flags <= match_flags | hit;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      register_access_flag <= bkpt_pkg::status_reset[bkpt_pkg::st_bd];
    else if (guard_fault)
      register_access_flag <= 1'b1;
    else if (wr_status)
      register_access_flag <= pwdata[bkpt_pkg::st_bd];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      single_step_flag <= bkpt_pkg::status_reset[bkpt_pkg::st_bs];
    else if (step_trap)
      single_step_flag <= 1'b1;
    else if (wr_status)
      single_step_flag <= pwdata[bkpt_pkg::st_bs];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      task_switch_flag <= bkpt_pkg::status_reset[bkpt_pkg::st_bt];
    else if (task_trap)
      task_switch_flag <= 1'b1;
    else if (wr_status)
      task_switch_flag <= pwdata[bkpt_pkg::st_bt];
  end

  // Status word: reserved bits except bit 12 read as ones, flags at their positions
  always_comb
  begin
    status = bkpt_pkg::status_reset & ~bkpt_pkg::status_rw_mask;
    status[3:0] = match_flags;
    status[bkpt_pkg::st_bd] = register_access_flag;
    status[bkpt_pkg::st_bs] = single_step_flag;
    status[bkpt_pkg::st_bt] = task_switch_flag;
  end

  // Control register with hardware side effects
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      control <= bkpt_pkg::control_reset;
    else
    begin
      if (wr_control)
        control <= (pwdata & bkpt_pkg::control_rw_mask) | bkpt_pkg::control_reset;
      if (task_switch)
      begin
        for (int i = 0; i < 4; i++)
          control[2 * i] <= 1'b0;
      end
      if (debug_exc)
        control[bkpt_pkg::ctl_gd] <= 1'b0;
    end
  end

  // Breakpoint address registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 4; i++)
        bp_addr[i] <= 32'h0;
    end
    else if (wr_addr)
      bp_addr[reg_idx[1:0]] <= pwdata;
  end

  // Extension enable register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ctl4 <= 32'h0;
    else if (wr_ext)
      ctl4 <= pwdata & (32'h1 << bkpt_pkg::cr4_de);
  end

  // Read mux; alias slots read as zero when extensions are on
  always_comb
  begin
    next_rdata = 32'h0;
    if (reg_sel)
    begin
      unique case (reg_idx)
        3'h0, 3'h1, 3'h2, 3'h3: next_rdata = bp_addr[reg_idx[1:0]];
        bkpt_pkg::idx_alias_status: next_rdata = de ? 32'h0 : status;
        bkpt_pkg::idx_alias_control: next_rdata = de ? 32'h0 : control;
        bkpt_pkg::idx_status: next_rdata = status;
        default: next_rdata = control;
      endcase
    end
    else if (paddr == bkpt_pkg::off_ctl4)
      next_rdata = ctl4;
  end

  // APB answer: one wait state, so pready pulses once per transfer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // Unmapped words give pslverr with pready; their writes are dropped
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pslverr <= 1'b0;
    else
      pslverr <= psel & penable & ~pready & ~reg_sel & ~ext_sel;
  end

  // Read data stands only in the pready cycle and is zero otherwise
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prdata <= 32'h0;
    else
      prdata <= rd_first ? next_rdata : 32'h0;
  end

  // undefined opcode for an extended alias slot
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      undef_opcode <= 1'b0;
    else
      undef_opcode <= alias_access;
  end

  // faults win before, traps after
  // The vector reads zero while no exception is requested, so the
  // pipeline never sees a stale vector beside a low valid
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      exc <= '0;
    else
    begin
      exc.valid <= debug_exc | int3_trap;
      exc.fault <= exec_fault | guard_fault;
      if (debug_exc)
        exc.vector <= bkpt_pkg::vec_debug;
      else if (int3_trap)
        exc.vector <= bkpt_pkg::vec_break;
      else
        exc.vector <= '0;
    end
  end
endmodule : bkpt_unit

// *** verif/bkpt_unit_asserts.sv ***
// Port checker for the breakpoint unit, bound to each instance.
// Assumes one core clock and a synchronous active-low reset.
module bkpt_unit_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire bkpt_pkg::cycle_t cyc,
  input wire logic retire,
  input wire logic [7:0] retire_opcode,
  input wire logic trap_flag,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  input wire logic dreg_decode,
  input wire logic [2:0] dreg_num,
  input wire bkpt_pkg::exc_t exc,
  input wire logic undef_opcode
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [9:0] trap_dbg = {2'b10, bkpt_pkg::vec_debug};
  localparam logic [9:0] trap_brk = {2'b10, bkpt_pkg::vec_break};
  logic flt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Faults outrank traps in one cycle, so trap checks leave them out
  assign flt = dreg_decode || (cyc.valid && cyc.is_exec);

  AST_RST_QUIET: assert property (disable iff (1'b0) !rst_b |=> !exc.valid && !pready)
    else $error("output active after reset");
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a pulse one cycle after access");
  AST_STEP:
    assert property (retire && trap_flag && !task_switch && !flt |=> exc == trap_dbg)
    else $error("no single step trap");
  AST_TASK:
    assert property (task_switch && task_trap_bit && !flt |=> exc == trap_dbg)
    else $error("no task switch trap");
  AST_INT3:
    assert property (retire && retire_opcode == bkpt_pkg::op_int3 && !trap_flag
      && !task_switch && !dreg_decode && !cyc.valid |=> exc == trap_brk)
    else $error("no vector three trap");
  AST_FAULT_CAUSE:
    assert property (exc.valid && exc.fault |-> $past(flt) && exc.vector == bkpt_pkg::vec_debug)
    else $error("fault without a fault cause");
  AST_TRAP_AFTER:
    assert property (exc.valid && !exc.fault |-> $past(retire || task_switch))
    else $error("trap before completion");
  AST_UNDEF_SLOT:
    assert property (undef_opcode |-> $past(dreg_decode && dreg_num[2:1] == 2'h2))
    else $error("undefined opcode without alias access");
endmodule : bkpt_unit_asserts

bind bkpt_unit bkpt_unit_asserts chk (.*);

// *** verif/core_pipe_model.sv ***
// Model of the pipeline and bus logic that feeds the breakpoint unit.
// Assumes the bench calls issue() from one process, one event at a time.
module core_pipe_model (
  input wire logic clk,
  output bkpt_pkg::cycle_t cyc,
  output logic retire,
  output logic [7:0] retire_opcode,
  output logic trap_flag,
  output logic task_switch,
  output logic task_trap_bit,
  output logic dreg_decode,
  output logic [2:0] dreg_num
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quiet at time zero
  initial
  begin
    cyc = '0;
    {retire, retire_opcode, trap_flag, task_switch, task_trap_bit, dreg_decode, dreg_num} = '0;
  end
  // Kinds: 0 fetch, 1 write, 2 I/O, 3 read, 4 int3 retire, 5 task switch, 6 debug reg
  // Bit 0 of rn is the segment's debug trap bit on a task switch
  task automatic issue(input logic [2:0] k, input logic [31:0] a, input logic [1:0] s,
    input logic tf, input logic [2:0] rn);
    @(posedge clk);
    cyc <= {k < 3'h4, k == 3'h0, k == 3'h1, k == 3'h2, a, s};
    retire <= k != 3'h0 && k < 3'h5;
    retire_opcode <= (k == 3'h4) ? bkpt_pkg::op_int3 : 8'h90;
    trap_flag <= tf;
    task_switch <= k == 3'h5;
    task_trap_bit <= rn[0];
    dreg_decode <= k == 3'h6;
    dreg_num <= rn;
    // Released fields show inverted stale values so nothing matches by luck
    @(posedge clk);
    cyc <= {4'h0, ~a, ~s};
    retire_opcode <= ~retire_opcode;
    dreg_num <= ~rn;
    {retire, task_switch, task_trap_bit, dreg_decode} <= 4'h0;
  endtask : issue
endmodule : core_pipe_model

// *** verif/test_bkpt_unit.sv ***
// Self-checking bench for the breakpoint unit.
// Assumes the pipeline model drives events; APB is driven here.
module test_bkpt_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, retire, trap_flag, task_switch, task_trap_bit, dreg_decode;
  logic undef_opcode, er;
  logic [7:0] retire_opcode;
  logic [2:0] dreg_num;
  bkpt_pkg::cycle_t cyc;
  bkpt_pkg::exc_t exc;
  int n_errors = 0, checked = 0, cycles = 0;
  // Row: kind, address, size-1, expected exception, expected match flags
  localparam logic [50:0] rows [8] = '{
    {3'h0, 32'h00001000, 2'h0, 10'h301, 4'h1}, {3'h1, 32'h00002002, 2'h1, 10'h201, 4'h2},
    {3'h3, 32'h00002001, 2'h0, 10'h000, 4'h0}, {3'h2, 32'h00000301, 2'h0, 10'h201, 4'h4},
    {3'h3, 32'h00004001, 2'h0, 10'h000, 4'h8}, {3'h4, 32'h00000000, 2'h0, 10'h203, 4'h0},
    {3'h0, 32'h00001001, 2'h0, 10'h000, 4'h0}, {3'h1, 32'h00001FFF, 2'h1, 10'h201, 4'h2}};
  localparam logic [31:0] bpa [4] = '{32'h1000, 32'h2000, 32'h300, 32'h4000};
  // bp0 fetch local, bp1 write 4B global, bp2 I/O 2B local, bp3 data 2B off
  localparam logic [31:0] ctl = 32'h76D00319;

  bkpt_unit dut (.*);
  core_pipe_model pipe (.*);

  always #2 clk = ~clk;
  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic ev(input logic [2:0] k, input logic [31:0] a, input logic tf,
    input logic [2:0] rn, input logic [9:0] want);
    pipe.issue(k, a, 2'h0, tf, rn);
    #1 chk({22'h0, exc}, {22'h0, want});
  endtask : ev

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (2) @(posedge clk);
    #1 chk({21'h0, exc, pready}, 32'h0);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdc(8'h18, bkpt_pkg::status_reset);
    rdc(8'h10, bkpt_pkg::status_reset);
    rdc(8'h14, bkpt_pkg::control_reset);
    rdc(8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h14, 32'h00000300);
    rdc(8'h1C, 32'h00000700);
    // Extensions go on before any I/O type is chosen
    apb(1'b1, 8'h20, 32'h00000008);
    for (int i = 0; i < 4; i++)
      apb(1'b1, 8'(i * 4), bpa[i]);
    apb(1'b1, 8'h1C, ctl);
    rdc(8'h1C, ctl | 32'h400);
    // Ordinary cases: flags cleared, one event, exception and flags checked
    foreach (rows[i])
    begin
      apb(1'b1, 8'h18, 32'h0);
      pipe.issue(rows[i][50:48], rows[i][47:16], rows[i][15:14], 1'b0, 3'h0);
      #1 chk({22'h0, exc}, {22'h0, rows[i][13:4]});
      rdc(8'h18, 32'hFFFF0FF0 | rows[i][3:0]);
    end
    // Single step on an int3 retire: the debug vector wins
    apb(1'b1, 8'h18, 32'h0);
    ev(3'h4, 32'h0, 1'b1, 3'h0, 10'h201);
    rdc(8'h18, 32'hFFFF4FF0);
    // Task switch drops local enables only; earlier flags stay
    ev(3'h5, 32'h0, 1'b0, 3'h1, 10'h201);
    ev(3'h5, 32'h0, 1'b0, 3'h0, 10'h000);
    rdc(8'h18, 32'hFFFFCFF0);
    rdc(8'h1C, 32'h76D00708);
    ev(3'h0, 32'h1000, 1'b0, 3'h0, 10'h000);
    ev(3'h1, 32'h2000, 1'b0, 3'h0, 10'h201);
    rdc(8'h18, 32'hFFFFCFF3);
    // Guarded register access faults and clears the guard
    apb(1'b1, 8'h1C, 32'h76D02708);
    ev(3'h6, 32'h0, 1'b0, 3'h0, 10'h301);
    rdc(8'h18, 32'hFFFFEFF3);
    rdc(8'h1C, 32'h76D00708);
    // Alias slot with extensions on and no guard
    ev(3'h6, 32'h0, 1'b0, 3'h4, 10'h000);
    chk({31'h0, undef_opcode}, 32'h1);
    test_done();
  end
endmodule : test_bkpt_unit
